// *** design/cdmp_paging.sv ***
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "cdmp_consts.svh"

module cdmp_paging #(
	parameter int STACK_DEPTH = 16
) (
	input  wire logic                clk_in,
	input  wire logic                reset_in,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [7:0]          paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output logic [31:0]              prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	input  wire logic                step_in,
	input  wire logic [15:0]         instr_in,
	input  wire logic                ret_in,
	input  wire logic                branch_in,
	input  wire logic [15:0]         branch_target_in,
	input  wire logic                irq_call_in,
	input  wire logic                cpr_load_in,
	input  wire logic                dpr_load_in,
	input  wire logic [3:0]          page_in,
	input  wire logic                dsel_set_in,
	input  wire logic                dsel_clr_in,
	input  wire logic                dacc_req_in,
	input  wire logic                dacc_write_in,
	input  wire logic                dacc_byte_in,
	input  wire logic [15:0]         tos_in,
	input  wire logic [15:0]         nos_in,
	output logic [18:0]              mem_addr_bus_out,
	output logic [15:0]              mem_wdata_out,
	output logic [1:0]               mem_be_out,
	output logic                     mem_we_out,
	output logic                     mem_re_out,
	input  wire logic [15:0]         mem_rdata_in,
	output logic [15:0]              nos_out,
	output logic                     nos_valid_out,
	output logic                     irq_hold_out,
	output logic                     data_page_select_out
);
	localparam int SP_W = $clog2(STACK_DEPTH);

	function automatic logic is_call(input logic [15:0] ins);
		is_call = ~ins[`CDMP_INSTR_KIND_BIT];
	endfunction

	function automatic logic [7:0] word_index(input logic [7:0] byte_addr);
		word_index = {2'b00, byte_addr[7:2]};
	endfunction

	cdmp_pkg::cdmp_page_t    code_page_reg, code_page_next;
	cdmp_pkg::cdmp_page_t    pend_page_reg, pend_page_next;
	logic                    pend_reg, pend_next;
	cdmp_pkg::cdmp_page_t    data_page_reg, data_page_next;
	cdmp_pkg::cdmp_word_t    int_base_ctrl_reg, int_base_ctrl_next;
	cdmp_pkg::cdmp_word_t    config_reg, config_next;
	cdmp_pkg::cdmp_word_t    ret_word_reg, ret_word_next;
	cdmp_pkg::cdmp_rpage_t   ret_page_reg, ret_page_next;
	cdmp_pkg::cdmp_word_t    pc_reg, pc_next;
	logic [SP_W-1:0]         sp_reg;
	cdmp_pkg::cdmp_retaddr_t stack_mem [STACK_DEPTH];
	logic                    block_reg;
	logic                    acc_valid_reg, acc_we_reg, acc_byte_reg, acc_swap_reg;
	logic [18:0]             acc_addr_reg;
	logic [15:0]             acc_wdata_reg;
	logic [1:0]              acc_be_reg;
	logic [15:0]             nos_reg;
	logic                    nos_valid_reg;

	wire       apb_wr      = psel_in & penable_in & pwrite_in;
	wire [7:0] apb_idx     = word_index(paddr_in);
	wire       apb_mapped  = (apb_idx >= `CDMP_IDX_RET_WORD) && (apb_idx <= `CDMP_IDX_RET_PAGE)
		&& (paddr_in[1:0] == 2'b00);
	wire       wr_code     = apb_wr & (apb_idx == `CDMP_IDX_CODE_PAGE);
	wire       wr_data     = apb_wr & (apb_idx == `CDMP_IDX_DATA_PAGE);
	wire       wr_ibc      = apb_wr & (apb_idx == `CDMP_IDX_IBC);
	wire       wr_cfg      = apb_wr & (apb_idx == `CDMP_IDX_CONFIG);
	wire       wr_rword    = apb_wr & (apb_idx == `CDMP_IDX_RET_WORD);
	wire       wr_rpage    = apb_wr & (apb_idx == `CDMP_IDX_RET_PAGE);

	wire       ret_step    = step_in & ret_in;
	wire       call_step   = step_in & ~ret_in & (is_call(instr_in) | irq_call_in);
	wire       cp_load     = (step_in & cpr_load_in) | wr_code;
	wire [3:0] cp_new      = wr_code ? pwdata_in[3:0] : page_in;
	wire       dsel        = int_base_ctrl_reg[`CDMP_IBC_DSEL_BIT];
	wire       order       = config_reg[`CDMP_CFG_ORDER_BIT];
	wire [15:0] pc_seq     = 16'(pc_reg + `CDMP_PC_STEP);
	wire [20:0] pop_word   = stack_mem[sp_reg - SP_W'(1)];

	wire [15:0] call_target = {instr_in[14:0], 1'b0};

	always_comb begin
		pc_next = pc_seq;
		if (ret_step) begin
			pc_next = {ret_word_reg[15:1], 1'b0};
		end else if (call_step) begin
			pc_next = call_target;
		end else if (step_in & branch_in) begin
			pc_next = {branch_target_in[15:1], 1'b0};
		end else if (!step_in) begin
			pc_next = pc_reg;
		end
	end

	assign code_page_next = ret_step ? ret_page_reg[3:0]
		: (step_in & pend_reg) ? pend_page_reg : code_page_reg;
	assign pend_next      = cp_load | (pend_reg & ~step_in);
	assign pend_page_next = cp_load ? cp_new : pend_page_reg;
	assign data_page_next = wr_data ? pwdata_in[3:0] : (step_in & dpr_load_in) ? page_in : data_page_reg;
	assign config_next    = wr_cfg ? pwdata_in[15:0] : config_reg;

	always_comb begin
		int_base_ctrl_next = wr_ibc ? pwdata_in[15:0] : int_base_ctrl_reg;
		if (ret_step) begin
			int_base_ctrl_next[`CDMP_IBC_DSEL_BIT] = ret_page_reg[`CDMP_RPG_DSEL_BIT];
		end else if (dsel_set_in) begin
			int_base_ctrl_next[`CDMP_IBC_DSEL_BIT] = 1'b1;
		end else if (dsel_clr_in) begin
			int_base_ctrl_next[`CDMP_IBC_DSEL_BIT] = 1'b0;
		end
	end

	always_comb begin
		ret_word_next = wr_rword ? pwdata_in[15:0] : ret_word_reg;
		ret_page_next = wr_rpage ? pwdata_in[4:0] : ret_page_reg;
		if (call_step) begin
			ret_word_next = {pc_seq[15:1], irq_call_in};
			ret_page_next = {dsel, code_page_reg};
		end else if (ret_step) begin
			ret_word_next = pop_word[15:0];
			ret_page_next = pop_word[20:16];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			code_page_reg     <= `CDMP_RST_PAGE;
			pend_page_reg     <= `CDMP_RST_PAGE;
			pend_reg          <= 1'b0;
			data_page_reg     <= `CDMP_RST_PAGE;
			int_base_ctrl_reg <= `CDMP_RST_WORD;
			config_reg        <= `CDMP_RST_WORD;
			ret_word_reg      <= `CDMP_RST_WORD;
			ret_page_reg      <= `CDMP_RST_RET_PAGE;
			pc_reg            <= `CDMP_RST_WORD;
			sp_reg            <= '0;
			block_reg         <= 1'b0;
		end else begin
			code_page_reg     <= code_page_next;
			pend_page_reg     <= pend_page_next;
			pend_reg          <= pend_next;
			data_page_reg     <= data_page_next;
			int_base_ctrl_reg <= int_base_ctrl_next;
			config_reg        <= config_next;
			ret_word_reg      <= ret_word_next;
			ret_page_reg      <= ret_page_next;
			pc_reg            <= pc_next;
			block_reg         <= cp_load;
			if (call_step) begin
				sp_reg <= SP_W'(sp_reg + SP_W'(1));
			end else if (ret_step) begin
				sp_reg <= SP_W'(sp_reg - SP_W'(1));
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (call_step) begin
			stack_mem[sp_reg] <= {ret_page_reg, ret_word_reg};
		end
	end

	wire [3:0]  dpage      = dsel ? data_page_reg : code_page_reg;
	wire        lane_odd   = tos_in[0] ^ order;
	wire        word_swap  = tos_in[0] ^ order;
	wire [15:0] wdata_word = word_swap ? {nos_in[7:0], nos_in[15:8]} : nos_in;
	wire [15:0] wdata_sel  = dacc_byte_in ? {nos_in[7:0], nos_in[7:0]} : wdata_word;
	wire [1:0]  be_sel     = !dacc_byte_in ? 2'b11 : (lane_odd ? 2'b01 : 2'b10);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			acc_valid_reg <= 1'b0;
			acc_we_reg    <= 1'b0;
			acc_byte_reg  <= 1'b0;
			acc_swap_reg  <= 1'b0;
			acc_addr_reg  <= '0;
			acc_wdata_reg <= `CDMP_RST_WORD;
			acc_be_reg    <= 2'b00;
		end else begin
			acc_valid_reg <= dacc_req_in;
			acc_we_reg    <= dacc_req_in & dacc_write_in;
			acc_byte_reg  <= dacc_byte_in;
			acc_swap_reg  <= dacc_byte_in ? lane_odd : word_swap;
			acc_addr_reg  <= {dpage, tos_in[15:1]};
			acc_wdata_reg <= wdata_sel;
			acc_be_reg    <= dacc_req_in ? be_sel : 2'b00;
		end
	end

	wire [15:0] rd_word = acc_swap_reg ? {mem_rdata_in[7:0], mem_rdata_in[15:8]} : mem_rdata_in;
	wire [15:0] rd_byte = {8'h00, acc_swap_reg ? mem_rdata_in[7:0] : mem_rdata_in[15:8]};

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			nos_reg       <= `CDMP_RST_WORD;
			nos_valid_reg <= 1'b0;
		end else begin
			nos_valid_reg <= acc_valid_reg & ~acc_we_reg;
			if (acc_valid_reg & ~acc_we_reg) begin
				nos_reg <= acc_byte_reg ? rd_byte : rd_word;
			end
		end
	end

	wire [18:0] fetch_addr = {code_page_reg, pc_reg[15:1]};

	assign mem_addr_bus_out     = acc_valid_reg ? acc_addr_reg : fetch_addr;
	assign mem_wdata_out        = acc_wdata_reg;
	assign mem_be_out           = acc_be_reg;
	assign mem_we_out           = acc_we_reg;
	assign mem_re_out           = ~acc_we_reg;
	assign nos_out              = nos_reg;
	assign nos_valid_out        = nos_valid_reg;
	assign irq_hold_out         = block_reg;
	assign data_page_select_out = dsel;

	wire [15:0] rd_mux =
		(apb_idx == `CDMP_IDX_RET_WORD)  ? ret_word_reg :
		(apb_idx == `CDMP_IDX_CODE_PAGE) ? {12'h000, code_page_reg} :
		(apb_idx == `CDMP_IDX_DATA_PAGE) ? {12'h000, data_page_reg} :
		(apb_idx == `CDMP_IDX_IBC)       ? int_base_ctrl_reg :
		(apb_idx == `CDMP_IDX_CONFIG)    ? config_reg :
		(apb_idx == `CDMP_IDX_RET_PAGE)  ? {11'h000, ret_page_reg} : 16'h0000;
	assign prdata_out  = {16'h0000, apb_mapped ? rd_mux : 16'h0000};
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~apb_mapped;

	// Checks
	a_call_target: assert property (@(posedge clk_in) disable iff (reset_in)
		call_step && !irq_call_in |=> pc_reg == {$past(instr_in[14:0]), 1'b0})
		else $error("call target wrong");
	a_call_page: assert property (@(posedge clk_in) disable iff (reset_in)
		call_step && !pend_reg |=> $stable(code_page_reg))
		else $error("call changed page");
	a_page_delay: assert property (@(posedge clk_in) disable iff (reset_in)
		step_in && cpr_load_in && !ret_in && !pend_reg ##1 step_in && !ret_in
		|-> $stable(code_page_reg) ##1 code_page_reg == $past(pend_page_reg))
		else $error("code page delay wrong");
	a_irq_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		cp_load |=> irq_hold_out ##1 (irq_hold_out == $past(cp_load)))
		else $error("interrupt hold wrong");
	a_ret_word: assert property (@(posedge clk_in) disable iff (reset_in)
		call_step |=> ret_word_reg == {$past(pc_seq[15:1]), $past(irq_call_in)})
		else $error("return word wrong");
	a_ret_page: assert property (@(posedge clk_in) disable iff (reset_in)
		call_step |=> ret_page_reg == {$past(dsel), $past(code_page_reg)})
		else $error("return page wrong");
	a_dsel_restore: assert property (@(posedge clk_in) disable iff (reset_in)
		ret_step |=> dsel == $past(ret_page_reg[4]))
		else $error("select not restored");
	a_byte_lane: assert property (@(posedge clk_in) disable iff (reset_in)
		dacc_req_in && dacc_byte_in |=> mem_be_out == ($past(tos_in[0] ^ order) ? 2'b01 : 2'b10))
		else $error("byte lane wrong");
	a_byte_read: assert property (@(posedge clk_in) disable iff (reset_in)
		acc_valid_reg && !acc_we_reg && acc_byte_reg |=> nos_valid_out && nos_out[15:8] == 8'h00)
		else $error("byte read upper not clear");
	a_fetch_page: assert property (@(posedge clk_in) disable iff (reset_in)
		!acc_valid_reg |-> mem_addr_bus_out[18:15] == code_page_reg)
		else $error("fetch page wrong");
endmodule // cdmp_paging

// *** design/cdmp_consts.svh ***
`ifndef CDMP_CONSTS_SVH
`define CDMP_CONSTS_SVH

// Register indices, byte address is four times the index
`define CDMP_IDX_RET_WORD   8'h01
`define CDMP_IDX_CODE_PAGE  8'h02
`define CDMP_IDX_DATA_PAGE  8'h03
`define CDMP_IDX_IBC        8'h04
`define CDMP_IDX_CONFIG     8'h05
`define CDMP_IDX_RET_PAGE   8'h06

// Field positions
`define CDMP_IBC_DSEL_BIT   5
`define CDMP_CFG_ORDER_BIT  2
`define CDMP_RPG_DSEL_BIT   4
`define CDMP_INSTR_KIND_BIT 15

// Reset values and PC step
`define CDMP_RST_PAGE       4'h0
`define CDMP_RST_WORD       16'h0000
`define CDMP_RST_RET_PAGE   5'h00
`define CDMP_PC_STEP        16'h0002

`endif

// *** design/cdmp_pkg.sv ***
package cdmp_pkg;
	typedef logic [3:0]  cdmp_page_t;
	typedef logic [15:0] cdmp_word_t;
	typedef logic [4:0]  cdmp_rpage_t;
	typedef logic [20:0] cdmp_retaddr_t;
endpackage

// *** testbench/cdmp_mem_model.sv ***
`timescale 1ns/1ps
module cdmp_mem_model (
	input  wire logic        clk_in,
	input  wire logic [18:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [1:0]  be_in,
	input  wire logic        we_in,
	input  wire logic        re_in,
	output logic [15:0]      rdata_out
);
	logic [15:0] mem_reg [256];
	logic [15:0] last_reg = 16'h0000;
	// Bus shows the inverse of the last word read while re_in is low
	assign rdata_out = re_in ? mem_reg[addr_in[7:0]] : ~last_reg;
	initial foreach (mem_reg[i]) mem_reg[i] = 16'h0000;
	always @(posedge clk_in) begin
		if (re_in) last_reg <= mem_reg[addr_in[7:0]];
		if (we_in && be_in[1]) mem_reg[addr_in[7:0]][15:8] <= wdata_in[15:8];
		if (we_in && be_in[0]) mem_reg[addr_in[7:0]][7:0] <= wdata_in[7:0];
	end
endmodule // cdmp_mem_model

// *** testbench/code_data_memory_paging_tb_top.sv ***
`timescale 1ns/1ps
`include "cdmp_consts.svh"
module code_data_memory_paging_tb_top;
	logic        clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
	logic        pready_out, pslverr_out, step_in = 1'b0, ret_in = 1'b0, irq_call_in = 1'b0, cpr_load_in = 1'b0;
	logic [15:0] instr_in = 16'h0000, tos_in = 16'h0000, nos_in = 16'h0000, mem_wdata_out, mem_rdata_in, nos_out;
	logic [15:0] t1, t2, t3, m;
	logic [3:0]  page_in = 4'h0;
	logic        dsel_set_in = 1'b0, dsel_clr_in = 1'b0, dacc_req_in = 1'b0, dacc_write_in = 1'b0;
	logic        dacc_byte_in = 1'b0, mem_we_out, mem_re_out, nos_valid_out, irq_hold_out, data_page_select_out;
	logic        o, s, er;
	logic        branch_in = 1'b0, dpr_load_in = 1'b0;
	logic [15:0] branch_target_in = 16'h0000;
	logic [18:0] mem_addr_bus_out;
	logic [1:0]  mem_be_out;
	int          errors = 0, total_checks = 0, cycles = 0;

	cdmp_paging u_dut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .step_in, .instr_in, .ret_in, .branch_in, .branch_target_in,
		.irq_call_in, .cpr_load_in, .dpr_load_in, .page_in, .dsel_set_in, .dsel_clr_in, .dacc_req_in,
		.dacc_write_in, .dacc_byte_in, .tos_in, .nos_in, .mem_addr_bus_out, .mem_wdata_out, .mem_be_out,
		.mem_we_out, .mem_re_out, .mem_rdata_in, .nos_out, .nos_valid_out, .irq_hold_out, .data_page_select_out);
	cdmp_mem_model u_mem (.clk_in, .addr_in(mem_addr_bus_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
		.we_in(mem_we_out), .re_in(mem_re_out), .rdata_out(mem_rdata_in));

	initial forever #25 clk_in = ~clk_in;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			end_of_test;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= {idx[5:0], 2'b00};
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic stp(input logic [15:0] ins, input logic cl, input logic rt, input logic iq, input logic [3:0] pg);
		@(posedge clk_in);
		step_in <= 1'b1;
		instr_in <= ins;
		cpr_load_in <= cl;
		ret_in <= rt;
		irq_call_in <= iq;
		page_in <= pg;
	endtask

	task automatic idle;
		@(posedge clk_in);
		step_in <= 1'b0;
		cpr_load_in <= 1'b0;
		ret_in <= 1'b0;
		irq_call_in <= 1'b0;
		dsel_set_in <= 1'b0;
		dsel_clr_in <= 1'b0;
		dacc_req_in <= 1'b0;
		branch_in <= 1'b0;
		dpr_load_in <= 1'b0;
	endtask

	task automatic fet(input logic [18:0] e);
		@(negedge clk_in);
		chk("fetch_addr", {13'h0000, e}, {13'h0000, mem_addr_bus_out});
	endtask

	task automatic dacc(input logic w, input logic bt, input logic [15:0] t, input logic [15:0] n, input logic [3:0] pg);
		logic sw;
		sw = t[0] ^ o;
		@(posedge clk_in);
		dacc_req_in <= 1'b1;
		dacc_write_in <= w;
		dacc_byte_in <= bt;
		tos_in <= t;
		nos_in <= n;
		idle;
		@(negedge clk_in);
		chk("data_addr", {pg, t[15:1]}, mem_addr_bus_out);
		chk("mem_we", w, mem_we_out);
		chk("mem_re", !w, mem_re_out);
		if (w) chk("mem_be", bt ? (sw ? 2'b01 : 2'b10) : 2'b11, mem_be_out);
		if (w) chk("mem_wdata", bt ? {n[7:0], n[7:0]} : (sw ? {n[7:0], n[15:8]} : n), mem_wdata_out);
		if (w && bt) m = sw ? {m[15:8], n[7:0]} : {n[7:0], m[7:0]};
		if (w && !bt) m = sw ? {n[7:0], n[15:8]} : n;
		if (!w) begin
			@(negedge clk_in);
			chk("nos_valid", 1, nos_valid_out);
			chk("nos", bt ? {8'h00, sw ? m[7:0] : m[15:8]} : (sw ? {m[7:0], m[15:8]} : m), nos_out);
		end
	endtask

	initial begin
		void'($urandom(32'had67));
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 1; i < 7; i++) begin
			apb(1'b0, i[7:0], 32'h0000_0000);
			chk("reset_value", 0, rd);
			chk("pslverr_mapped", 0, er);
		end
		apb(1'b0, 8'h0f, 32'h0000_0000);
		chk("unmapped_read", 0, rd);
		chk("pslverr_unmapped", 1, er);
		$display("test registers done");
		t1 = 16'($urandom()) & 16'hfff0;
		t2 = 16'($urandom()) & 16'hfffe;
		t3 = 16'($urandom()) & 16'hfffe;
		stp({1'b0, t1[15:1]}, 1'b0, 1'b0, 1'b0, 4'h0);
		idle;
		fet({4'h0, t1[15:1]});
		apb(1'b0, `CDMP_IDX_RET_WORD, 32'h0000_0000);
		chk("ret_word", 32'h0000_0002, rd);
		apb(1'b1, `CDMP_IDX_DATA_PAGE, 32'h0000_0009);
		stp(16'h8000, 1'b1, 1'b0, 1'b0, 4'h4);
		stp({1'b0, t2[15:1]}, 1'b0, 1'b0, 1'b0, 4'h0);
		fet({4'h0, t1[15:1] + 15'h0001});
		chk("irq_hold", 1, irq_hold_out);
		idle;
		fet({4'h4, t2[15:1]});
		chk("irq_hold_end", 0, irq_hold_out);
		apb(1'b0, `CDMP_IDX_RET_WORD, 32'h0000_0000);
		chk("ret_word", {16'h0000, t1 + 16'h0004}, rd);
		apb(1'b0, `CDMP_IDX_RET_PAGE, 32'h0000_0000);
		chk("ret_page", 0, rd);
		apb(1'b1, `CDMP_IDX_RET_PAGE, 32'h0000_0010);
		stp(16'h8000, 1'b0, 1'b1, 1'b0, 4'h0);
		idle;
		fet({4'h0, t1[15:1] + 15'h0002});
		chk("dsel_restored", 1, data_page_select_out);
		apb(1'b0, `CDMP_IDX_RET_WORD, 32'h0000_0000);
		chk("ret_word_popped", 32'h0000_0002, rd);
		stp(16'h8000, 1'b1, 1'b0, 1'b0, 4'h7);
		stp(16'h8000, 1'b0, 1'b0, 1'b0, 4'h0);
		idle;
		fet({4'h7, t1[15:1] + 15'h0004});
		stp({1'b0, t3[15:1]}, 1'b0, 1'b0, 1'b1, 4'h0);
		idle;
		fet({4'h7, t3[15:1]});
		apb(1'b0, `CDMP_IDX_RET_WORD, 32'h0000_0000);
		chk("ret_word_irq", {16'h0000, t1 + 16'h000b}, rd);
		apb(1'b0, `CDMP_IDX_RET_PAGE, 32'h0000_0000);
		chk("ret_page", 32'h0000_0017, rd);
		stp(16'h8000, 1'b1, 1'b0, 1'b0, 4'h5);
		stp(16'h8000, 1'b0, 1'b0, 1'b0, 4'hb);
		branch_in <= 1'b1;
		branch_target_in <= t2;
		dpr_load_in <= 1'b1;
		idle;
		fet({4'h5, t2[15:1]});
		$display("test calls done");
		for (int k = 0; k < 12; k++) begin
			o = 1'($urandom());
			s = 1'($urandom());
			apb(1'b1, `CDMP_IDX_CONFIG, {29'h0, o, 2'b00});
			@(posedge clk_in);
			dsel_set_in <= s;
			dsel_clr_in <= !s;
			idle;
			@(negedge clk_in);
			chk("dsel", s, data_page_select_out);
			apb(1'b0, `CDMP_IDX_IBC, 32'h0000_0000);
			chk("ibc_dsel", s, rd[5]);
			t1 = 16'($urandom());
			dacc(1'b1, 1'b0, t1, 16'($urandom()), s ? 4'hb : 4'h5);
			dacc(1'b1, 1'b1, {t1[15:1], 1'($urandom())}, 16'($urandom()), s ? 4'hb : 4'h5);
			dacc(1'b0, 1'($urandom()), {t1[15:1], 1'($urandom())}, 16'h0000, s ? 4'hb : 4'h5);
		end
		$display("test data done");
		end_of_test;
	end
endmodule // code_data_memory_paging_tb_top
